// *** rtl/sms_standby_seq.sv ***
// Standby mode sequencer with AXI4-Lite register slave
//
// Notes on behaviour
// - Any reset starts the device in main internal oscillator clock mode.
// - After reset wait for main and sub oscillator stabilization before running.
// - Writing one to sleep request bit enters sleep.
// - Sleep ends on reset or any peripheral interrupt.
// - Deep standby: sleep wake stays asleep until flash recovery ends.
// - Timer or watch wake passes through sleep for flash recovery.
// - Running from RAM skips every flash recovery wait.
// - Writing one to stop request bit enters stop.
// - Stop ends on external interrupt, then oscillator and flash waits.
// - Short oscillator wait: sleep after it until flash recovery ends.
// - Long oscillator wait: run directly once stabilization completes.
// - Timer standby request in main clock modes enters time-base timer mode.
// - Timer standby request in sub clock modes enters watch mode.
// - Sleep gates CPU and watchdog clocks; other peripherals keep running.
// - Watchdog enabled for standby keeps sub oscillator and watchdog running.
// - Deep standby disable bit zero imposes flash wait; one skips it.
// - Main clock modes: flash wait at most 10 SCLK, 150 us, 6 MCLK.
// - Sub clock modes: flash wait at most 2 SCLK, 150 us, 6 MCLK.
`timescale 1ns/1ps
`default_nettype none
`include "sms_cfg.svh"

module sms_standby_seq #(
    parameter int unsigned FLASH_MAIN_CYC = 16'(`SMS_FLASH_CYC + 10 + 6),
    parameter int unsigned FLASH_SUB_CYC  = 16'(`SMS_FLASH_CYC + 2 + 6),
    parameter int unsigned OSC_MAIN_CYC   = 16'h0100,
    parameter int unsigned OSC_SUB_CYC    = 16'h1000,
    parameter int unsigned OSC_RESET_CYC  = 16'h1000
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        clk_en,
    input  wire logic [`SMS_CLK_MODE_W-1:0]  clk_mode,
    input  wire logic                        periph_irq,
    input  wire logic                        ext_irq,
    input  wire logic [`SMS_ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output var  logic                        s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output var  logic                        s_axi_wready,
    output var  logic [1:0]                  s_axi_bresp,
    output var  logic                        s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [`SMS_ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output var  logic                        s_axi_arready,
    output var  logic [31:0]                 s_axi_rdata,
    output var  logic [1:0]                  s_axi_rresp,
    output var  logic                        s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output var  logic                        cpu_clk_en,
    output var  logic                        wdt_clk_en,
    output var  logic                        periph_clk_en,
    output var  logic                        sub_osc_en,
    output var  logic                        hw_wdt_run
);

    ////////////////////////////////////////////////////////////////////////////
    // State and registers
    sms_pkg::sms_state_type state_q;
    sms_pkg::sms_state_type state_d;
    logic [`SMS_CNT_W-1:0]  osc_cnt_q;
    logic [`SMS_CNT_W-1:0]  osc_cnt_d;
    logic [`SMS_CNT_W-1:0]  fl_cnt_q;
    logic [`SMS_CNT_W-1:0]  fl_cnt_d;
    logic                   dstby_dis_q;
    logic                   ram_exec_q;
    logic                   wdt_stby_q;
    logic                   aw_q;
    logic                   w_q;
    logic [`SMS_ADDR_W-1:0] awaddr_q;
    logic [31:0]            wdata_q;
    logic                   wstrb0_q;

    ////////////////////////////////////////////////////////////////////////////
    // Clock mode decode and wait lengths
    wire sub_mode  = (clk_mode == `SMS_CM_SUB) || (clk_mode == `SMS_CM_SUB_INTERNAL_OSC);
    wire main_mode = (clk_mode == `SMS_CM_MAIN) || (clk_mode == `SMS_CM_MAIN_INTERNAL_OSC)
                   || (clk_mode == `SMS_CM_MAIN_PLL);
    wire [`SMS_CNT_W-1:0] flash_len = sub_mode ? `SMS_CNT_W'(FLASH_SUB_CYC)
                                               : `SMS_CNT_W'(FLASH_MAIN_CYC);
    wire [`SMS_CNT_W-1:0] osc_len   = sub_mode ? `SMS_CNT_W'(OSC_SUB_CYC) : `SMS_CNT_W'(OSC_MAIN_CYC);
    wire                  need_flash = !dstby_dis_q && !ram_exec_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus write decode
    wire       wr_go     = aw_q && w_q && !s_axi_bvalid;
    wire       wr_ctrl   = wr_go && (awaddr_q == `SMS_OFF_CTRL) && wstrb0_q;
    wire       wr_ctrl2  = wr_go && (awaddr_q == `SMS_OFF_CTRL2) && wstrb0_q;
    wire       wr_cfg    = wr_go && (awaddr_q == `SMS_OFF_CFG) && wstrb0_q;
    wire       wr_known  = (awaddr_q == `SMS_OFF_CTRL) || (awaddr_q == `SMS_OFF_CTRL2)
                         || (awaddr_q == `SMS_OFF_STAT) || (awaddr_q == `SMS_OFF_CFG);
    wire       running   = (state_q == sms_pkg::SMS_RUN);
    wire       req_sleep = wr_ctrl && running && wdata_q[`SMS_BIT_SLEEP];
    wire       req_stop  = wr_ctrl && running && wdata_q[`SMS_BIT_STOP];
    wire       req_tmr   = wr_ctrl && running && wdata_q[`SMS_BIT_TMR];
    wire       any_irq   = periph_irq || ext_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Bus read decode
    wire       rd_go    = s_axi_arvalid && s_axi_arready;
    wire       rd_ctrl2 = (s_axi_araddr == `SMS_OFF_CTRL2);
    wire       rd_ctrl  = (s_axi_araddr == `SMS_OFF_CTRL);
    wire       rd_stat  = (s_axi_araddr == `SMS_OFF_STAT);
    wire       rd_cfg   = (s_axi_araddr == `SMS_OFF_CFG);
    wire [31:0] rd_val  = rd_ctrl2 ? {31'h0, dstby_dis_q}
                        : rd_stat ? {25'h0, state_q}
                        : rd_cfg  ? {30'h0, wdt_stby_q, ram_exec_q}
                        : 32'h0;
    wire       rd_ok    = rd_ctrl || rd_ctrl2 || rd_stat || rd_cfg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_d   = state_q;
        osc_cnt_d = (osc_cnt_q != `SMS_ZERO_CNT) ? osc_cnt_q - `SMS_ONE_CNT : osc_cnt_q;
        fl_cnt_d  = (fl_cnt_q != `SMS_ZERO_CNT) ? fl_cnt_q - `SMS_ONE_CNT : fl_cnt_q;
        case (state_q)
            sms_pkg::SMS_RESET_WAIT: begin
                if (osc_cnt_q == `SMS_ZERO_CNT) begin
                    if (need_flash) begin
                        state_d  = sms_pkg::SMS_SLEEP;
                        fl_cnt_d = flash_len;
                    end else begin
                        state_d = sms_pkg::SMS_RUN;
                    end
                end
            end
            sms_pkg::SMS_RUN: begin
                if (req_stop) begin
                    state_d = sms_pkg::SMS_STOP;
                end else if (req_tmr && main_mode) begin
                    state_d = sms_pkg::SMS_TBT;
                end else if (req_tmr && sub_mode) begin
                    state_d = sms_pkg::SMS_WATCH;
                end else if (req_sleep) begin
                    state_d  = sms_pkg::SMS_SLEEP;
                    fl_cnt_d = `SMS_ZERO_CNT;
                end
            end
            sms_pkg::SMS_SLEEP: begin
                // Recovery sleep ends as its count runs out; plain sleep keeps a zero count
                if (fl_cnt_q == `SMS_ONE_CNT) begin
                    state_d = sms_pkg::SMS_RUN;
                end else if ((fl_cnt_q == `SMS_ZERO_CNT) && periph_irq) begin
                    if (need_flash) begin
                        fl_cnt_d = flash_len;
                    end else begin
                        state_d = sms_pkg::SMS_RUN;
                    end
                end
            end
            sms_pkg::SMS_TBT, sms_pkg::SMS_WATCH: begin
                if (any_irq) begin
                    if (need_flash) begin
                        state_d  = sms_pkg::SMS_SLEEP;
                        fl_cnt_d = flash_len;
                    end else begin
                        state_d = sms_pkg::SMS_RUN;
                    end
                end
            end
            sms_pkg::SMS_STOP: begin
                if (ext_irq) begin
                    state_d   = sms_pkg::SMS_OSC_WAIT;
                    osc_cnt_d = osc_len;
                    fl_cnt_d  = need_flash ? flash_len : `SMS_ZERO_CNT;
                end
            end
            sms_pkg::SMS_OSC_WAIT: begin
                if (osc_cnt_q == `SMS_ZERO_CNT) begin
                    if (fl_cnt_q > `SMS_ONE_CNT) begin
                        state_d = sms_pkg::SMS_SLEEP;
                    end else begin
                        state_d = sms_pkg::SMS_RUN;
                    end
                end
            end
            default: begin
                state_d = sms_pkg::SMS_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and configuration flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= sms_pkg::SMS_RESET_WAIT;
            osc_cnt_q   <= `SMS_CNT_W'(OSC_RESET_CYC);
            fl_cnt_q    <= `SMS_ZERO_CNT;
            dstby_dis_q <= `SMS_CTRL2_RST;
            {wdt_stby_q, ram_exec_q} <= `SMS_CFG_RST;
        end else if (clk_en) begin
            state_q   <= state_d;
            osc_cnt_q <= osc_cnt_d;
            fl_cnt_q  <= fl_cnt_d;
            if (wr_ctrl2) begin
                dstby_dis_q <= wdata_q[`SMS_BIT_DSTBY_DIS];
            end
            if (wr_cfg) begin
                ram_exec_q <= wdata_q[`SMS_BIT_RAM_EXEC];
                wdt_stby_q <= wdata_q[`SMS_BIT_WDT_STBY];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock gating outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en    <= 1'b0;
            wdt_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
            sub_osc_en    <= 1'b1;
            hw_wdt_run    <= 1'b0;
        end else if (clk_en) begin
            cpu_clk_en    <= (state_d == sms_pkg::SMS_RUN);
            wdt_clk_en    <= (state_d == sms_pkg::SMS_RUN);
            periph_clk_en <= (state_d == sms_pkg::SMS_RUN) || (state_d == sms_pkg::SMS_SLEEP);
            sub_osc_en    <= (state_d != sms_pkg::SMS_STOP) && (state_d != sms_pkg::SMS_TBT)
                             || wdt_stby_q;
            hw_wdt_run    <= (state_d == sms_pkg::SMS_RUN) || wdt_stby_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q          <= 1'b0;
            awaddr_q      <= `SMS_ADDR_W'(0);
            s_axi_awready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q          <= 1'b0;
            wdata_q      <= 32'h0;
            wstrb0_q     <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_q      <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write response channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SMS_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `SMS_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // sms_standby_seq
`default_nettype wire

// *** rtl/sms_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the standby sequencer
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH
`define SMS_ADDR_W          4
`define SMS_OFF_CTRL        4'h0
`define SMS_OFF_CTRL2       4'h4
`define SMS_OFF_STAT        4'h8
`define SMS_OFF_CFG         4'hC
`define SMS_BIT_SLEEP       0
`define SMS_BIT_STOP        1
`define SMS_BIT_TMR         2
`define SMS_BIT_DSTBY_DIS   0
`define SMS_BIT_RAM_EXEC    0
`define SMS_BIT_WDT_STBY    1
`define SMS_CTRL2_RST       1'b0
`define SMS_CFG_RST         2'b00
`define SMS_CLK_MODE_W      3
`define SMS_CM_SUB          3'h0
`define SMS_CM_MAIN         3'h2
`define SMS_CM_SUB_INTERNAL_OSC       3'h4
`define SMS_CM_MAIN_INTERNAL_OSC      3'h6
`define SMS_CM_MAIN_PLL     3'h7
`define SMS_CNT_W           16
`define SMS_CLK_NS          20
`define SMS_FLASH_US        150
`define SMS_FLASH_NS        (`SMS_FLASH_US * 1000)
`define SMS_FLASH_CYC       (`SMS_FLASH_NS / `SMS_CLK_NS)
`define SMS_RESP_OKAY       2'h0
`define SMS_RESP_SLVERR     2'h2
`define SMS_ONE_CNT         16'h0001
`define SMS_ZERO_CNT        16'h0000
`endif

// *** rtl/sms_pkg.sv ***
// Types of the standby sequencer
package sms_pkg;
    typedef enum logic [6:0] {
        SMS_RESET_WAIT = 7'h01,
        SMS_RUN        = 7'h02,
        SMS_SLEEP      = 7'h04,
        SMS_STOP       = 7'h08,
        SMS_TBT        = 7'h10,
        SMS_WATCH      = 7'h20,
        SMS_OSC_WAIT   = 7'h40
    } sms_state_type;
endpackage

// *** tb/sms_standby_props.sv ***
// Port checker of the standby sequencer
`timescale 1ns/1ps
`default_nettype none
module sms_standby_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        cpu_clk_en,
    input wire logic        wdt_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        sub_osc_en,
    input wire logic        hw_wdt_run
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_wait_dark: assert property ($rose(aresetn) |-> (!cpu_clk_en && !periph_clk_en) [*8])
        else $error("cpu or peripherals clocked during reset stabilisation");
    a_reset_sub_osc: assert property ($rose(aresetn) |-> sub_osc_en)
        else $error("sub oscillator off after reset");
    a_cpu_wdt_pair: assert property (cpu_clk_en == wdt_clk_en)
        else $error("watchdog clock differs from cpu clock");
    a_run_periph_on: assert property (cpu_clk_en |-> periph_clk_en)
        else $error("peripherals stopped while cpu runs");
    a_wdt_keeps_osc: assert property (hw_wdt_run |-> sub_osc_en)
        else $error("watchdog counting without sub oscillator");
    a_run_wdt_on: assert property (cpu_clk_en |-> hw_wdt_run)
        else $error("hardware watchdog idle in run");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    c_sleeping: cover property (periph_clk_en && !cpu_clk_en);
    c_dark_stop: cover property (!periph_clk_en && !sub_osc_en);
    c_osc_wait: cover property (s_axi_rvalid && s_axi_rdata[6]);
endmodule // sms_standby_props
`default_nettype wire

// *** tb/sms_irq_src.sv ***
// Peripheral and external interrupt sources
`timescale 1ns/1ps
`default_nettype none
module sms_irq_src (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic fire_periph,
    input  wire logic fire_ext,
    output var  logic periph_irq,
    output var  logic ext_irq
);
    logic [2:0] p_cnt_q;
    logic [2:0] e_cnt_q;
    // Each request holds its line four cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p_cnt_q <= 3'h0;
            e_cnt_q <= 3'h0;
        end else begin
            p_cnt_q <= fire_periph ? 3'h4 : p_cnt_q - 3'(p_cnt_q != 3'h0);
            e_cnt_q <= fire_ext ? 3'h4 : e_cnt_q - 3'(e_cnt_q != 3'h0);
        end
    end
    assign periph_irq = (p_cnt_q != 3'h0);
    assign ext_irq    = (e_cnt_q != 3'h0);
endmodule // sms_irq_src
`default_nettype wire

// *** tb/tb_sms_standby_seq.sv ***
// Self-checking bench of the standby sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sms_cfg.svh"
module tb_sms_standby_seq;
    logic        aclk = 1'b0, aresetn = 1'b0, fire_p = 1'b0, fire_e = 1'b0, clr_sl = 1'b0, saw_sl = 1'b0;
    logic [2:0]  clk_mode = `SMS_CM_MAIN_INTERNAL_OSC;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ce = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid, cpu_en, wdt_en, per_en, sub_en, wdt_run, p_irq, e_irq;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  modes [5] = '{`SMS_CM_SUB, `SMS_CM_MAIN, `SMS_CM_SUB_INTERNAL_OSC, `SMS_CM_MAIN_INTERNAL_OSC, `SMS_CM_MAIN_PLL};
    int          n_errors = 0, n_checks = 0, cyc = 0;
    sms_standby_seq #(.FLASH_MAIN_CYC(40), .FLASH_SUB_CYC(20), .OSC_MAIN_CYC(10), .OSC_SUB_CYC(60),
        .OSC_RESET_CYC(16)) sms_standby_seq_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
        .clk_mode(clk_mode), .periph_irq(p_irq), .ext_irq(e_irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_clk_en(cpu_en), .wdt_clk_en(wdt_en), .periph_clk_en(per_en), .sub_osc_en(sub_en),
        .hw_wdt_run(wdt_run));
    sms_irq_src sms_irq_src_inst (.aclk(aclk), .aresetn(aresetn), .fire_periph(fire_p), .fire_ext(fire_e),
        .periph_irq(p_irq), .ext_irq(e_irq));
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        saw_sl <= clr_sl ? 1'b0 : (saw_sl | (per_en & ~cpu_en));
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task print_verdict;
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task wait_st(input logic [31:0] e);
        int i;
        i = 0;
        do begin
            rd(`SMS_OFF_STAT, v);
            i++;
        end while (v !== e && i < 300);
        chk(v, e);
    endtask
    task fire(input logic ext);
        @(posedge aclk);
        if (ext) fire_e <= 1'b1;
        else fire_p <= 1'b1;
        @(posedge aclk);
        fire_e <= 1'b0;
        fire_p <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SMS_OFF_STAT, v);
        chk(v, 32'(sms_pkg::SMS_RESET_WAIT));
        rd(`SMS_OFF_CTRL2, v);
        chk(v, 32'h0);
        // Write with byte lane zero off is ignored
        wstrb <= 4'hE;
        wr(`SMS_OFF_CTRL2, 32'h1);
        wstrb <= 4'hF;
        rd(`SMS_OFF_CTRL2, v);
        chk(v, 32'h0);
        rd(4'h2, v);
        chk(32'(resp), 32'(`SMS_RESP_SLVERR));
        wait_st(32'(sms_pkg::SMS_RUN));
        wr(`SMS_OFF_CFG, 32'h2);
        wr(`SMS_OFF_CTRL, 32'h1);
        rd(`SMS_OFF_STAT, v);
        chk(v, 32'(sms_pkg::SMS_SLEEP));
        chk(32'({per_en, cpu_en, wdt_en}), 32'h4);
        chk(32'({wdt_run, sub_en}), 32'h3);
        fire(1'b0);
        repeat (15) @(posedge aclk);
        rd(`SMS_OFF_STAT, v);
        chk(v, 32'(sms_pkg::SMS_SLEEP));
        // Frozen clock enable holds the recovery count
        ce <= 1'b0;
        repeat (60) @(posedge aclk);
        ce <= 1'b1;
        rd(`SMS_OFF_STAT, v);
        chk(v, 32'(sms_pkg::SMS_SLEEP));
        wait_st(32'(sms_pkg::SMS_RUN));
        // Normal standby, then deep standby running from RAM
        for (int k = 0; k < 2; k++) begin
            wr(`SMS_OFF_CTRL2, 32'(k == 0));
            wr(`SMS_OFF_CFG, 32'(k));
            wr(`SMS_OFF_CTRL, 32'h1);
            fire(1'b0);
            rd(`SMS_OFF_STAT, v);
            chk(v, 32'(sms_pkg::SMS_RUN));
        end
        wr(`SMS_OFF_CFG, 32'h0);
        for (int k = 0; k < 5; k++) begin
            clk_mode <= modes[k];
            wr(`SMS_OFF_CTRL, 32'h4);
            rd(`SMS_OFF_STAT, v);
            chk(v, modes[k][1] ? 32'(sms_pkg::SMS_TBT) : 32'(sms_pkg::SMS_WATCH));
            fire(1'b0);
            rd(`SMS_OFF_STAT, v);
            chk(v, 32'(sms_pkg::SMS_SLEEP));
            wait_st(32'(sms_pkg::SMS_RUN));
        end
        // Stop with short, then long oscillator wait
        for (int k = 0; k < 2; k++) begin
            clk_mode <= k ? `SMS_CM_SUB : `SMS_CM_MAIN_INTERNAL_OSC;
            wr(`SMS_OFF_CFG, 32'(k * 2));
            wr(`SMS_OFF_CTRL, 32'h3);
            rd(`SMS_OFF_STAT, v);
            chk(v, 32'(sms_pkg::SMS_STOP));
            chk(32'({sub_en, wdt_run}), k ? 32'h3 : 32'h0);
            fire(1'b0);
            rd(`SMS_OFF_STAT, v);
            chk(v, 32'(sms_pkg::SMS_STOP));
            clr_sl <= 1'b1;
            fire(1'b1);
            clr_sl <= 1'b0;
            repeat (16) @(posedge aclk);
            rd(`SMS_OFF_STAT, v);
            chk(v, k ? 32'(sms_pkg::SMS_OSC_WAIT) : 32'(sms_pkg::SMS_SLEEP));
            wait_st(32'(sms_pkg::SMS_RUN));
            chk(32'(saw_sl), 32'(k == 0));
        end
        print_verdict();
    end
endmodule // tb_sms_standby_seq
bind sms_standby_seq sms_standby_props sms_standby_props_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .cpu_clk_en(cpu_clk_en), .wdt_clk_en(wdt_clk_en),
    .periph_clk_en(periph_clk_en), .sub_osc_en(sub_osc_en), .hw_wdt_run(hw_wdt_run));
`default_nettype wire
